// [aseg_conv_model.sv]
// behavioural analog converter seen at the convReq/convDone side of aseg_core
// assumes one clock shared with the core and convChan valid with convReq
module aseg_conv_model (
    input  logic        clk,
    input  logic        rst_n,
    input  logic        convReq,
    input  logic [3:0]  convChan,
    input  logic        convAbort,
    output logic        convDone,
    output logic [11:0] convValue
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       active;
    logic [1:0] cnt;
    logic [3:0] chan;

    initial begin
        convDone = 1'b0;
        convValue = 12'h000;
    end

    // ************************************************************
    // conversion timing
    // ************************************************************
    // result 12'h100 + channel; value toggles between results to expose stale samples
    always @(posedge clk) begin
        if (!rst_n || convAbort) begin
            active <= 1'b0;
            convDone <= #1 1'b0;
        end else if (convReq) begin
            active <= 1'b1;
            chan <= convChan;
            cnt <= 2'h2;
            convDone <= #1 1'b0;
            convValue <= #1 ~convValue;
        end else if (active && cnt == 2'h0) begin
            active <= 1'b0;
            convDone <= #1 1'b1;
            convValue <= #1 12'h100 + {8'h00, chan};
        end else begin
            if (active) cnt <= cnt - 2'h1;
            convDone <= #1 1'b0;
            convValue <= #1 ~convValue;
        end
    end
endmodule

// [aseg_core.v]
// scan sequencer with scan-end requests, event-link outputs and compare
// assumes the analog converter answers each convReq with one convDone pulse
`include "aseg_defines.vh"

// Functional notes
// - outside double and group modes, each single scan end raises scan-end request.
// - in double trigger mode, request follows the second scan only.
// - in group mode, group A scan end raises the main request.
// - group B scan end raises its own separate request.
// - double plus group: main request after two group A scans, B unchanged.
// - both requests can start the data transfer and DMA controllers.
// - event-link pulse on every scan end other than group B.
// - extended variant: event-link pulse on group B scan end.
// - extended variant: event-link pulse at end of all scans.
// - event link controller trigger starts a scan.
// - extended, single mode: event-link pulse when window compare conditions hold.
// - extended: windows A and B with 16-deep ring buffer of results.
// - double trigger mode keeps both results in data and duplicate registers.
// - repeated conversions are added, or averaged on the extended variant.
// - extended: data registers clear automatically when read.
// - module stop halts scanning, result stores and event outputs; the read port still serves reads.
// - group mode splits channels; each trigger converts each selected channel once, group A only its lowest one in double mode.
// - group A priority aborts group B; optional rescan of group B afterwards.
module aseg_core #(
    parameter EXTENDED = 1,
    parameter NCH      = `ASEG_NUM_CHAN
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        clkEn,
    input  wire        moduleStop,
    input  wire        groupScanMode,
    input  wire        doubleTrigMode,
    input  wire        groupAPriority,
    input  wire        groupBRescan,
    input  wire [15:0] chanSelA,
    input  wire [15:0] chanSelB,
    input  wire        swTrigA,
    input  wire        elcTrigA,
    input  wire        trigB,
    input  wire        averageMode,
    input  wire [1:0]  addCount,
    input  wire        autoClear,
    input  wire        scanEndIrqEn,
    input  wire        groupBIrqEn,
    input  wire        elcGroupBEn,
    input  wire        elcAllEn,
    input  wire        elcCompareEn,
    input  wire [15:0] cmpChanA,
    input  wire [15:0] cmpLoA,
    input  wire [15:0] cmpHiA,
    input  wire        cmpOutsideA,
    input  wire        cmpEnB,
    input  wire [3:0]  cmpChanB,
    input  wire [15:0] cmpLoB,
    input  wire [15:0] cmpHiB,
    input  wire        cmpOutsideB,
    input  wire [1:0]  cmpCombine,
    output reg         convReq,
    output reg  [3:0]  convChan,
    output reg         convAbort,
    input  wire        convDone,
    input  wire [11:0] convValue,
    input  wire [4:0]  rdAddr,
    input  wire        rdStrobe,
    output reg  [15:0] rdData,
    input  wire [3:0]  ringRdIdx,
    output wire [21:0] ringRdData,
    output wire [4:0]  ringCount,
    output wire        busy,
    output reg         scanEndIrq,
    output reg         groupBScanEndIrq,
    output reg         elcScanEnd,
    output reg         elcGroupBEnd,
    output reg         elcAllEnd,
    output reg         elcCompare
);

    localparam ST_IDLE = 2'h0;
    localparam ST_REQ  = 2'h1;
    localparam ST_WAIT = 2'h2;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // lowest selected channel at or above a start index, NONE if empty
    function [4:0] firstFrom;
        input [15:0] mask;
        input [4:0]  from;
        integer i;
        begin
            firstFrom = `ASEG_CHAN_NONE;
            for (i = 15; i >= 0; i = i - 1) begin
                if (mask[i] && (i >= from)) begin
                    firstFrom = i[4:0];
                end
            end
        end
    endfunction

    // window test: inside the levels, or outside when asked for
    function winHit;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        input        outside;
        begin
            winHit = ((v >= lo) && (v <= hi)) ^ outside;
        end
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    reg  [1:0]  state;
    reg         scanB;
    reg  [15:0] scanMask;
    reg  [4:0]  chan;
    reg  [2:0]  repLeft;
    reg  [15:0] acc;
    reg         dblSecond;
    reg         pendB;
    reg         hitA;
    reg         hitB;
    reg  [15:0] dataReg [0:NCH-1];
    reg  [15:0] dupReg;

    wire        ext       = (EXTENDED != 0);
    wire        trigA     = swTrigA | elcTrigA;
    wire [15:0] lowA      = chanSelA & (~chanSelA + 16'h0001);
    wire [15:0] maskA     = doubleTrigMode ? lowA : chanSelA;
    wire [15:0] maskB     = chanSelB & ~chanSelA;
    wire [4:0]  firstA    = firstFrom(maskA, 5'h00);
    wire [4:0]  firstB    = firstFrom(maskB, 5'h00);
    wire [4:0]  nextChan  = firstFrom(scanMask, chan + 5'h01);
    wire        useAvg    = averageMode & ext;
    wire [2:0]  reps      = useAvg ? (3'h1 << addCount) - 3'h1 : {1'b0, addCount};
    wire [15:0] sum       = acc + {4'h0, convValue};
    wire [15:0] result    = useAvg ? (sum >> addCount) : sum;
    wire        lastConv  = (repLeft == 3'h0);
    wire        lastChan  = (nextChan == `ASEG_CHAN_NONE);
    wire        storing   = (state == ST_WAIT) && convDone && lastConv;
    wire        scanEnd   = storing && lastChan;
    wire        singleMd  = !groupScanMode && !doubleTrigMode;
    wire        inWinA    = cmpChanA[chan[3:0]];
    wire        inWinB    = cmpEnB && (cmpChanB == chan[3:0]);
    wire        curHitA   = winHit(result, cmpLoA, cmpHiA, cmpOutsideA);
    wire        curHitB   = winHit(result, cmpLoB, cmpHiB, cmpOutsideB);
    wire        endHitA   = hitA | (inWinA & curHitA);
    wire        endHitB   = hitB | (inWinB & curHitB);
    wire        abortB    = scanB && groupAPriority && trigA && (firstA != `ASEG_CHAN_NONE);
    wire        startA    = trigA && (firstA != `ASEG_CHAN_NONE);
    wire        startB    = groupScanMode && (trigB || pendB) && (firstB != `ASEG_CHAN_NONE);
    wire        ringPush  = ext && storing && singleMd && (inWinA || inWinB);
    reg         cmbHit;

    assign busy = (state != ST_IDLE);

    // combine the two windows the way software selected
    always @* begin
        if (cmpCombine == `ASEG_CMB_AND) begin
            cmbHit = endHitA & (endHitB | !cmpEnB);
        end else if (cmpCombine == `ASEG_CMB_XOR) begin
            cmbHit = endHitA ^ endHitB;
        end else begin
            cmbHit = endHitA | endHitB;
        end
    end

    // ****************************************************************
    // scan sequencer
    // ****************************************************************
    // a trigger arriving while busy is dropped, except the priority case
    always @(posedge clk) begin
        if (!rst_n || (clkEn && moduleStop)) begin
            state     <= `ASEG_STATE_RESET;
            scanB     <= 1'b0;
            scanMask  <= 16'h0000;
            chan      <= 5'h00;
            repLeft   <= 3'h0;
            acc       <= 16'h0000;
            dblSecond <= 1'b0;
            pendB     <= 1'b0;
            hitA      <= 1'b0;
            hitB      <= 1'b0;
            convReq   <= 1'b0;
            convChan  <= 4'h0;
            convAbort <= 1'b0;
        end else if (clkEn) begin
            convReq   <= 1'b0;
            convAbort <= 1'b0;
            if (!doubleTrigMode) begin
                dblSecond <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    acc     <= 16'h0000;
                    repLeft <= reps;
                    hitA    <= 1'b0;
                    hitB    <= 1'b0;
                    if (startA) begin
                        scanB    <= 1'b0;
                        scanMask <= maskA;
                        chan     <= firstA;
                        state    <= ST_REQ;
                    end else if (startB) begin
                        scanB    <= 1'b1;
                        scanMask <= maskB;
                        chan     <= firstB;
                        pendB    <= 1'b0;
                        state    <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (abortB) begin
                        convAbort <= 1'b1;
                        pendB     <= groupBRescan;
                        scanB     <= 1'b0;
                        scanMask  <= maskA;
                        chan      <= firstA;
                        acc       <= 16'h0000;
                        repLeft   <= reps;
                    end else begin
                        convReq  <= 1'b1;
                        convChan <= chan[3:0];
                        state    <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (abortB) begin
                        convAbort <= 1'b1;
                        pendB     <= groupBRescan;
                        scanB     <= 1'b0;
                        scanMask  <= maskA;
                        chan      <= firstA;
                        acc       <= 16'h0000;
                        repLeft   <= reps;
                        state     <= ST_REQ;
                    end else if (convDone) begin
                        if (!lastConv) begin
                            acc     <= sum;
                            repLeft <= repLeft - 3'h1;
                            state   <= ST_REQ;
                        end else begin
                            acc     <= 16'h0000;
                            repLeft <= reps;
                            hitA    <= endHitA;
                            hitB    <= endHitB;
                            if (lastChan) begin
                                state <= ST_IDLE;
                                if (doubleTrigMode && !scanB) begin
                                    dblSecond <= !dblSecond;
                                end
                            end else begin
                                chan  <= nextChan;
                                state <= ST_REQ;
                            end
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // result store and read port
    // ****************************************************************
    // a store in the same cycle as an auto-clearing read wins
    always @(posedge clk) begin
        if (!rst_n) begin
            dupReg <= `ASEG_DATA_RESET;
            rdData <= `ASEG_DATA_RESET;
        end else if (clkEn) begin
            if (rdStrobe) begin
                rdData <= (rdAddr == `ASEG_DUP_INDEX) ? dupReg : dataReg[rdAddr[3:0]];
                if (ext && autoClear && (rdAddr == `ASEG_DUP_INDEX)) begin
                    dupReg <= `ASEG_DATA_RESET;
                end
            end
            if (storing && !moduleStop && doubleTrigMode && dblSecond && !scanB) begin
                dupReg <= result;
            end
        end
    end

    // data registers; reset by the clocked loop so no async path exists
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : dataCell
            always @(posedge clk) begin
                if (!rst_n) begin
                    dataReg[g] <= `ASEG_DATA_RESET;
                end else if (clkEn) begin
                    if (storing && !moduleStop && (chan == g) &&
                        !(doubleTrigMode && dblSecond && !scanB)) begin
                        dataReg[g] <= result;
                    end else if (rdStrobe && ext && autoClear && (rdAddr == g)) begin
                        dataReg[g] <= `ASEG_DATA_RESET;
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // scan-end requests and event-link pulses
    // ****************************************************************
    // all outputs are one-cycle pulses in the cycle after the final store
    always @(posedge clk) begin
        if (!rst_n || (clkEn && moduleStop)) begin
            scanEndIrq       <= 1'b0;
            groupBScanEndIrq <= 1'b0;
            elcScanEnd       <= 1'b0;
            elcGroupBEnd     <= 1'b0;
            elcAllEnd        <= 1'b0;
            elcCompare       <= 1'b0;
        end else if (clkEn) begin
            scanEndIrq       <= scanEnd && !scanB && scanEndIrqEn &&
                                (!doubleTrigMode || dblSecond);
            groupBScanEndIrq <= scanEnd && scanB && groupBIrqEn;
            elcScanEnd       <= scanEnd && !scanB;
            elcGroupBEnd     <= ext && scanEnd && scanB && elcGroupBEn;
            elcAllEnd        <= ext && scanEnd && elcAllEn;
            elcCompare       <= ext && scanEnd && singleMd && elcCompareEn && cmbHit;
        end
    end

    // ****************************************************************
    // compare result ring buffer
    // ****************************************************************
    // entry: window B flag, window A hit, window B hit, channel, result
    aseg_ring #(
        .WIDTH (`ASEG_RING_WIDTH),
        .DEPTH (`ASEG_RING_DEPTH),
        .AW    (4)
    ) compareRing (
        .clk      (clk),
        .rst_n    (rst_n),
        .clkEn    (clkEn & !moduleStop),
        .push     (ringPush),
        .pushData ({inWinB, inWinA & curHitA, inWinB & curHitB, chan[2:0], result}),
        .rdIdx    (ringRdIdx),
        .rdData   (ringRdData),
        .count    (ringCount),
        .wrPtr    ()
    );

endmodule

// [aseg_core_asserts.sv]
// concurrent checks on the scan-end pulses and trigger handling of aseg_core
// assumes it is bound to aseg_core and sees its ports only
module aseg_core_asserts (
    input logic        clk,
    input logic        rst_n,
    input logic        clkEn,
    input logic        moduleStop,
    input logic        groupScanMode,
    input logic        doubleTrigMode,
    input logic [15:0] chanSelA,
    input logic        swTrigA,
    input logic        elcTrigA,
    input logic        scanEndIrqEn,
    input logic        elcGroupBEn,
    input logic        convReq,
    input logic        convDone,
    input logic        busy,
    input logic        scanEndIrq,
    input logic        groupBScanEndIrq,
    input logic        elcScanEnd,
    input logic        elcGroupBEnd,
    input logic        elcAllEnd,
    input logic        elcCompare
);
    timeunit 1ns;
    timeprecision 100ps;

    // ************************************************************
    // pulse shape and cause
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    irq_pulse_a: assert property (scanEndIrq |=> !scanEndIrq) else $error("scan end request longer than one cycle");
    conv_pulse_a: assert property (convReq |=> !convReq) else $error("conversion request longer than one cycle");
    irq_cause_a: assert property (scanEndIrq |-> $past(convDone) && $past(scanEndIrqEn)) else $error("scan end request without final result");
    all_end_a: assert property (elcAllEnd |-> $past(convDone)) else $error("all-scan event without final result");
    // a group B end must never look like a main scan end
    gb_only_a: assert property (groupBScanEndIrq |-> !scanEndIrq && !elcScanEnd && $past(groupScanMode))
        else $error("group B end mixed with main end");
    gb_elc_a: assert property (groupBScanEndIrq && elcGroupBEn |-> elcGroupBEnd) else $error("group B event missing");
    cmp_single_a: assert property (elcCompare |-> $past(!groupScanMode && !doubleTrigMode) && elcScanEnd)
        else $error("compare event outside single scan end");

    // ************************************************************
    // trigger and stop
    // ************************************************************
    trig_start_a: assert property ((swTrigA || elcTrigA) && !busy && !moduleStop && clkEn && chanSelA != 16'h0000
        |=> busy ##1 convReq) else $error("trigger did not start a scan");
    stop_idle_a: assert property (moduleStop && clkEn |=> !busy && !convReq) else $error("activity in module stop");
endmodule

// [aseg_defines.vh]
// constants shared by the scan-end event logic and its compare ring buffer
// assumes one 200 MHz clock; included by bare name from each design file
`ifndef ASEG_DEFINES_VH
`define ASEG_DEFINES_VH

// ****************************************************************
// sizes
// ****************************************************************
`define ASEG_NUM_CHAN       16
`define ASEG_CHAN_NONE      5'h10
`define ASEG_DUP_INDEX      5'h10
`define ASEG_RING_DEPTH     16
`define ASEG_RING_WIDTH     22
`define ASEG_DATA_WIDTH     16
`define ASEG_SAMPLE_WIDTH   12

// ****************************************************************
// window combine codes
// ****************************************************************
`define ASEG_CMB_OR         2'h0
`define ASEG_CMB_AND        2'h1
`define ASEG_CMB_XOR        2'h2

// ****************************************************************
// reset values
// ****************************************************************
`define ASEG_DATA_RESET     16'h0000
`define ASEG_STATE_RESET    2'h0

`endif

// [aseg_ring.v]
// ring buffer that keeps the most recent compare results
// assumes pushes are single-cycle pulses on the system clock
`include "aseg_defines.vh"

module aseg_ring #(
    parameter WIDTH = `ASEG_RING_WIDTH,
    parameter DEPTH = `ASEG_RING_DEPTH,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             clkEn,
    input  wire             push,
    input  wire [WIDTH-1:0] pushData,
    input  wire [AW-1:0]    rdIdx,
    output reg  [WIDTH-1:0] rdData,
    output reg  [AW:0]      count,
    output reg  [AW-1:0]    wrPtr
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    // parameters are 32 bits wide; cut them to the pointer and count widths on purpose
    wire [31:0]     lastFull  = DEPTH - 1;
    wire [31:0]     depthFull = DEPTH;
    wire [AW-1:0]   lastIdx   = lastFull[AW-1:0];

    // ****************************************************************
    // storage: the oldest entry is overwritten once the ring is full
    // ****************************************************************
    always @(posedge clk) begin
        if (clkEn && push) begin
            mem[wrPtr] <= pushData;
        end
    end

    // pointer and fill level; the count saturates at the depth
    always @(posedge clk) begin
        if (!rst_n) begin
            wrPtr  <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
            rdData <= {WIDTH{1'b0}};
        end else if (clkEn) begin
            rdData <= mem[rdIdx];
            if (push) begin
                wrPtr <= (wrPtr == lastIdx) ? {AW{1'b0}} : wrPtr + 1'b1;
                if (count != depthFull[AW:0]) begin
                    count <= count + 1'b1;
                end
            end
        end
    end

endmodule

// [tb.sv]
// self-checking bench for aseg_core with a behavioural converter on its far side
// assumes aseg_core, aseg_conv_model and aseg_core_asserts are compiled first
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk, rst_n, clkEn, moduleStop, groupScanMode, doubleTrigMode, groupAPriority, groupBRescan;
    logic        swTrigA, elcTrigA, trigB, averageMode, autoClear, scanEndIrqEn, groupBIrqEn, elcGroupBEn;
    logic        elcAllEn, elcCompareEn, cmpOutsideA, cmpEnB, cmpOutsideB, rdStrobe, convReq, convAbort;
    logic        convDone, busy, scanEndIrq, groupBScanEndIrq, elcScanEnd, elcGroupBEnd, elcAllEnd, elcCompare;
    logic [15:0] chanSelA, chanSelB, cmpChanA, cmpLoA, cmpHiA, cmpLoB, cmpHiB, rdData, v;
    logic [11:0] convValue;
    logic [21:0] ringRdData;
    logic [4:0]  rdAddr, ringCount;
    logic [3:0]  cmpChanB, convChan, ringRdIdx;
    logic [1:0]  addCount, cmpCombine;
    int          error_cnt, checks;
    int          n[7], s[7];

    // every port has a bench signal of the same name
    aseg_core u_dut (.*);

    aseg_conv_model u_conv (.clk(clk), .rst_n(rst_n), .convReq(convReq), .convChan(convChan), .convAbort(convAbort),
        .convDone(convDone), .convValue(convValue));

    // ************************************************************
    // clock, pulse counters, helpers
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // counters are never cleared; each scan compares against a snapshot
    always @(posedge clk) begin
        n[0] <= n[0] + int'(scanEndIrq === 1'b1);
        n[1] <= n[1] + int'(groupBScanEndIrq === 1'b1);
        n[2] <= n[2] + int'(elcScanEnd === 1'b1);
        n[3] <= n[3] + int'(elcGroupBEnd === 1'b1);
        n[4] <= n[4] + int'(elcAllEnd === 1'b1);
        n[5] <= n[5] + int'(elcCompare === 1'b1);
        n[6] <= n[6] + int'(convAbort === 1'b1);
    end

    task automatic chk(input logic [21:0] got, input logic [21:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic [21:0] d(input int i);
        return 22'(n[i] - s[i]);
    endfunction

    // kind 0 software trigger, 1 event link trigger, 2 group B trigger
    task automatic scan(input int kind);
        int k;
        s = n;
        @(posedge clk);
        #1;
        if (kind == 0) swTrigA = 1'b1;
        else if (kind == 1) elcTrigA = 1'b1;
        else trigB = 1'b1;
        @(posedge clk);
        #1;
        swTrigA = 1'b0;
        elcTrigA = 1'b0;
        trigB = 1'b0;
        // kind 3: group B trigger, then a group A trigger while B converts
        if (kind == 3) begin
            repeat (2) @(posedge clk);
            #1;
            swTrigA = 1'b1;
            @(posedge clk);
            #1;
            swTrigA = 1'b0;
        end
        for (k = 0; k < 300 && busy !== 1'b0; k++) begin
            @(posedge clk);
            #1;
        end
        chk(busy, 1'b0, "scan did not finish");
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        #1;
        rdAddr = a;
        rdStrobe = 1'b1;
        @(posedge clk);
        #1;
        rdStrobe = 1'b0;
        @(posedge clk);
        #1;
        v = rdData;
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_single();
        chanSelA = 16'h0005;
        scan(0);
        chk(d(0), 1, "single irq");
        chk(d(2), 1, "single event");
        chk(d(1), 0, "no group B irq");
        rd(5'h02);
        chk(v, 16'h0102, "channel 2 data");
        scanEndIrqEn = 1'b0;
        scan(0);
        chk(d(0), 0, "irq disabled");
        scanEndIrqEn = 1'b1;
        addCount = 2'h1;
        scan(1);
        rd(5'h00);
        chk(v, 16'h0200, "added result");
        averageMode = 1'b1;
        scan(0);
        rd(5'h00);
        chk(v, 16'h0100, "averaged result");
        averageMode = 1'b0;
        addCount = 2'h0;
        $display("test single done");
    endtask

    task automatic t_double();
        doubleTrigMode = 1'b1;
        chanSelA = 16'h0002;
        scan(0);
        chk(d(0), 0, "no irq after first");
        chk(d(2), 1, "event on first");
        scan(0);
        chk(d(0), 1, "irq after second");
        rd(5'h10);
        chk(v, 16'h0101, "duplicate data");
        rd(5'h01);
        chk(v, 16'h0101, "first data kept");
        doubleTrigMode = 1'b0;
        $display("test double done");
    endtask

    task automatic t_group();
        groupScanMode = 1'b1;
        chanSelA = 16'h0001;
        chanSelB = 16'h0010;
        scan(2);
        chk(d(1), 1, "group B irq");
        chk(d(0) | d(2), 0, "no main end on B");
        chk(d(3), 1, "group B event");
        chk(d(4), 1, "all scans event");
        rd(5'h04);
        chk(v, 16'h0104, "group B data");
        scan(0);
        chk(d(0), 1, "group A irq");
        chk(d(1), 0, "no B irq on A");
        doubleTrigMode = 1'b1;
        scan(0);
        chk(d(0), 0, "no irq after one A");
        scan(0);
        chk(d(0), 1, "irq after two A");
        scan(2);
        chk(d(1), 1, "B irq in double");
        doubleTrigMode = 1'b0;
        groupAPriority = 1'b1;
        scan(3);
        chk(d(6), 1, "abort pulse");
        chk(d(0), 1, "A irq after abort");
        chk(d(1) | d(3), 0, "aborted B silent");
        groupAPriority = 1'b0;
        groupScanMode = 1'b0;
        $display("test group done");
    endtask

    task automatic t_compare_stop();
        chanSelA = 16'h0005;
        cmpChanA = 16'h0001;
        scan(0);
        chk(d(5), 1, "compare event inside");
        chk(ringCount, 5'h01, "ring count");
        chk(ringRdData, 22'h100100, "ring entry");
        cmpOutsideA = 1'b1;
        scan(0);
        chk(d(5), 0, "no compare event outside");
        chk(ringCount, 5'h02, "ring count two");
        autoClear = 1'b1;
        rd(5'h02);
        rd(5'h02);
        chk(v, 16'h0000, "cleared after read");
        autoClear = 1'b0;
        moduleStop = 1'b1;
        scan(0);
        chk(d(0) | d(2), 0, "stopped module idle");
        moduleStop = 1'b0;
        $display("test compare and stop done");
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        {rst_n, moduleStop, groupScanMode, doubleTrigMode, groupAPriority, groupBRescan, swTrigA, elcTrigA} = 8'h00;
        {trigB, averageMode, autoClear, cmpOutsideA, cmpEnB, cmpOutsideB, rdStrobe} = 7'h00;
        {clkEn, scanEndIrqEn, groupBIrqEn, elcGroupBEn, elcAllEn, elcCompareEn} = 6'h3F;
        {chanSelA, chanSelB, cmpChanA, cmpLoA, cmpLoB, cmpHiB} = 96'h0;
        cmpHiA = 16'hFFFF;
        {cmpChanB, ringRdIdx, rdAddr, addCount, cmpCombine} = 17'h0;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_single();
        t_double();
        t_group();
        t_compare_stop();
        print_verdict();
    end

    initial begin
        #20000;
        error_cnt++;
        $display("ERROR %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule

bind aseg_core aseg_core_asserts u_chk (.*);
